// *** design/boot_mode_ctrl.v ***
// Reset-time mode selection, vector remap, boot ROM map and security erase
// Notes on behaviour
// - Special modes force A14 low on vectors
// - Map enable maps boot ROM for reset vector
// - Bootstrap reset sets map enable to one
// - Other modes reset map enable to zero
// - Test mode lets software set map enable
// - Secured part ignores mode A input when picking the mode
// - Security released only after full erase
// - Security disable sits at config bit 3
// - Bootstrap reads of config return default
// - Secured bootstrap or expanded start erases memories
// - Config value 05 maps EEPROM at 0800
`timescale 1ns/1ns
`default_nettype none
`include "boot_mode_map.vh"
module boot_mode_ctrl #(
   parameter ERASE_WORDS = 1024,
   parameter ERASE_AW = 10
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire mode_a_pin,
   input wire mode_b_pin,
   input wire [15:0] cpu_addr,
   input wire vector_fetch,
   output reg [15:0] mem_addr,
   output reg boot_rom_sel,
   output reg ee_win_sel,
   output reg special_mode_flag,
   output reg boot_rom_map_enable,
   output reg [1:0] op_mode,
   output reg cpu_hold,
   output wire wipe_we,
   output wire [ERASE_AW-1:0] wipe_addr
);
   // Start-up sequence states
   localparam ST_SAMPLE = 4'b0001;
   localparam ST_ERASE = 4'b0010;
   localparam ST_RUN = 4'b0100;
   localparam ST_WAIT = 4'b1000;

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [7:0] config_q;
   reg [7:0] config_d;
   reg [1:0] settle_q;
   reg [1:0] settle_d;
   reg erase_start_q;
   reg erase_start_d;
   reg erased_q;
   reg erased_d;
   reg sec_released_q;
   reg sec_released_d;
   reg [1:0] op_mode_d;
   reg special_mode_flag_d;
   reg boot_rom_map_enable_d;
   reg cpu_hold_d;
   reg [31:0] prdata_d;
   reg [15:0] mem_addr_d;
   reg boot_rom_sel_d;
   reg ee_win_sel_d;
   wire [1:0] mode_pins;
   wire erase_busy;
   wire erase_done;
   wire secured;
   wire [1:0] mode_sel;
   wire erase_needed;
   wire mode_latch;
   wire wr_en;
   wire rd_setup;
   wire ctrl_wr;
   wire erase_wr;
   wire config_wr;
   wire release_ok;

   // Decode a byte offset into a valid register hit
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_CONFIG) || (a == `OFS_ERASE);
      end
   endfunction

   // Inclusive address window test
   function in_window;
      input [15:0] a;
      input [15:0] lo;
      input [15:0] hi;
      begin
         in_window = (a >= lo) && (a <= hi);
      end
   endfunction

   // Mode pins cross into the clock domain first
   pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({mode_b_pin, mode_a_pin}),
      .sync_out(mode_pins)
   );

   // Memory wipe engine
   erase_sequencer #(
      .ADDR_W(ERASE_AW),
      .WORDS(ERASE_WORDS)
   ) u_erase (
      .pclk(pclk),
      .presetn(presetn),
      .start(erase_start_q),
      .busy(erase_busy),
      .done(erase_done),
      .wipe_we(wipe_we),
      .wipe_addr(wipe_addr)
   );

   // Security state from the nonvolatile word
   assign secured = ~config_q[`CFG_SEC_DIS_BIT];
   // Secured part reads mode A as zero, so mode B alone picks single-chip or bootstrap
   assign mode_sel = secured ? {mode_pins[1], 1'b0} : mode_pins;
   // A secured start with pins asking for bootstrap or expanded wipes the memories first
   assign erase_needed = secured && ((mode_sel == `MODE_SPECIAL_BOOT) || (mode_pins == `MODE_EXPANDED));
   // Pins are taken once the settle count has run out
   assign mode_latch = (state_q == ST_SAMPLE) && (settle_q == 2'b11);

   // Bus decode; the slave never inserts wait states
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pslverr = psel && penable && !mapped(paddr);
   assign ctrl_wr = wr_en && (paddr == `OFS_CTRL);
   assign erase_wr = wr_en && (paddr == `OFS_ERASE) && pwdata[`CTRL_ERASE_GO_BIT];
   assign config_wr = wr_en && (paddr == `OFS_CONFIG);
   // Lifting security needs a finished wipe and a bootstrap start
   assign release_ok = erased_q && (op_mode == `MODE_SPECIAL_BOOT);

   // Next state of the start-up sequence
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_SAMPLE:
            if (settle_q == 2'b11)
               state_d = erase_needed ? ST_ERASE : ST_RUN;
         ST_ERASE:
            state_d = ST_WAIT;
         ST_WAIT:
            if (erase_done)
               state_d = ST_RUN;
         ST_RUN:
            state_d = ST_RUN;
         default:
            state_d = ST_SAMPLE;
      endcase
   end

   // Settle count and operating mode taken from the pins
   always @*
   begin
      settle_d = settle_q;
      op_mode_d = op_mode;
      special_mode_flag_d = special_mode_flag;
      if ((state_q == ST_SAMPLE) && (settle_q != 2'b11))
         settle_d = settle_q + 2'b01;
      if (mode_latch)
      begin
         op_mode_d = mode_sel;
         special_mode_flag_d = ~mode_sel[1];
      end
   end

   // Map enable follows the start mode; software may set it only in a special mode
   always @*
   begin
      boot_rom_map_enable_d = boot_rom_map_enable;
      if (mode_latch)
         boot_rom_map_enable_d = (mode_sel == `MODE_SPECIAL_BOOT);
      if (ctrl_wr && special_mode_flag && (state_q == ST_RUN))
         boot_rom_map_enable_d = pwdata[`CTRL_BOOT_ROM_BIT];
   end

   // Erase start pulse, finished flag and CPU hold release
   always @*
   begin
      erase_start_d = 1'b0;
      erased_d = erased_q;
      cpu_hold_d = cpu_hold;
      if (state_q == ST_ERASE)
         erase_start_d = 1'b1;
      if (erase_wr && !erase_busy)
         erase_start_d = 1'b1;
      if (erase_done)
         erased_d = 1'b1;
      if (state_q == ST_RUN)
         cpu_hold_d = 1'b0;
   end

   // Configuration write; a write that lifts security is dropped until release is allowed
   always @*
   begin
      config_d = config_q;
      sec_released_d = sec_released_q;
      if (config_wr)
      begin
         if (secured && pwdata[`CFG_SEC_DIS_BIT])
         begin
            if (release_ok)
            begin
               config_d = pwdata[7:0];
               sec_released_d = 1'b1;
            end
         end
         else
            config_d = pwdata[7:0];
      end
   end

   // Start-up sequence registers; the CPU stays held until the sequence runs
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_SAMPLE;
         settle_q <= 2'b00;
         cpu_hold <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         settle_q <= settle_d;
         cpu_hold <= cpu_hold_d;
      end
   end

   // Latched operating mode and map enable
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_mode <= `MODE_SINGLE_CHIP;
         special_mode_flag <= 1'b0;
         boot_rom_map_enable <= 1'b0;
      end
      else
      begin
         op_mode <= op_mode_d;
         special_mode_flag <= special_mode_flag_d;
         boot_rom_map_enable <= boot_rom_map_enable_d;
      end
   end

   // Erase control registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         erase_start_q <= 1'b0;
         erased_q <= 1'b0;
      end
      else
      begin
         erase_start_q <= erase_start_d;
         erased_q <= erased_d;
      end
   end

   // Configuration word and security release flag
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         config_q <= `CFG_RESET_VALUE;
         sec_released_q <= 1'b0;
      end
      else
      begin
         config_q <= config_d;
         sec_released_q <= sec_released_d;
      end
   end

   // Read data chosen in the setup phase, held until the next read setup
   always @*
   begin
      prdata_d = prdata;
      if (rd_setup)
      begin
         case (paddr)
            `OFS_CTRL:
               prdata_d = {31'h0000_0000, boot_rom_map_enable};
            `OFS_STATUS:
               prdata_d = {24'h00_0000, sec_released_q, erased_q, erase_busy, secured,
                  special_mode_flag, cpu_hold, op_mode};
            `OFS_CONFIG:
               // Bootstrap mode shows the forced default, never the programmed word
               prdata_d = {24'h00_0000, (op_mode == `MODE_SPECIAL_BOOT) ? `CFG_FORCED_VALUE : config_q};
            `OFS_ERASE:
               prdata_d = {31'h0000_0000, erase_busy};
            default:
               prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Read data register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else
         prdata <= prdata_d;
   end

   // Vector remap, boot ROM and EEPROM window decode
   always @*
   begin
      if (vector_fetch && special_mode_flag)
         mem_addr_d = {cpu_addr[15], 1'b0, cpu_addr[13:0]};
      else
         mem_addr_d = cpu_addr;
      boot_rom_sel_d = boot_rom_map_enable && in_window(cpu_addr, `BOOT_ROM_BASE, 16'hFFFF);
      ee_win_sel_d = (config_q == `CFG_EE_AT_0800) &&
         in_window(cpu_addr, `EE_WIN_0800_BASE, `EE_WIN_0800_LAST);
   end

   // Memory-side outputs come from flip-flops
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_addr <= 16'h0000;
         boot_rom_sel <= 1'b0;
         ee_win_sel <= 1'b0;
      end
      else
      begin
         mem_addr <= mem_addr_d;
         boot_rom_sel <= boot_rom_sel_d;
         ee_win_sel <= ee_win_sel_d;
      end
   end
endmodule
`default_nettype wire

// *** design/boot_mode_map.vh ***
// Constants for the boot mode, boot ROM map and security block
`ifndef BOOT_MODE_MAP_VH
`define BOOT_MODE_MAP_VH

// APB register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_CONFIG 12'h008
`define OFS_ERASE 12'h00C

// Control and erase register fields
`define CTRL_BOOT_ROM_BIT 0
`define CTRL_ERASE_GO_BIT 1

// Configuration word fields
`define CFG_SEC_DIS_BIT 3
`define CFG_EE_MAP_LSB 4
`define CFG_RESET_VALUE 8'h0F
`define CFG_FORCED_VALUE 8'h0F
`define CFG_EE_AT_0800 8'h05

// EEPROM windows
`define EE_WIN_0800_BASE 16'h0800
`define EE_WIN_0800_LAST 16'h0FFF

// Mode encodings {mode_b, mode_a}
`define MODE_SPECIAL_BOOT 2'b00
`define MODE_SPECIAL_TEST 2'b01
`define MODE_SINGLE_CHIP 2'b10
`define MODE_EXPANDED 2'b11

// Erase timing
`define ERASE_TIME_NS 1000
`define CLK_PERIOD_NS 10
`define ERASE_CYCLES (`ERASE_TIME_NS / `CLK_PERIOD_NS)

// Boot ROM window
`define BOOT_ROM_BASE 16'hBF00
`define VEC_BASE 16'hFFC0

`endif

// *** design/erase_sequencer.v ***
// Sequencer that wipes on-chip EEPROM and RAM word by word
`timescale 1ns/1ns
`default_nettype none
module erase_sequencer #(
   parameter ADDR_W = 10,
   parameter WORDS = 1024
) (
   input wire pclk,
   input wire presetn,
   input wire start,
   output reg busy,
   output reg done,
   output reg wipe_we,
   output reg [ADDR_W-1:0] wipe_addr
);
   reg [ADDR_W:0] count_q;

   // Walk every address once, writing the blank value
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy <= 1'b0;
         done <= 1'b0;
         wipe_we <= 1'b0;
         wipe_addr <= {ADDR_W{1'b0}};
         count_q <= {(ADDR_W+1){1'b0}};
      end
      else if (start && !busy)
      begin
         busy <= 1'b1;
         done <= 1'b0;
         wipe_we <= 1'b1;
         wipe_addr <= {ADDR_W{1'b0}};
         count_q <= {(ADDR_W+1){1'b0}};
      end
      else if (busy)
      begin
         if (count_q == WORDS - 1)
         begin
            busy <= 1'b0;
            done <= 1'b1;
            wipe_we <= 1'b0;
         end
         else
         begin
            count_q <= count_q + 1'b1;
            wipe_addr <= wipe_addr + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** design/pin_sync.v ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter WIDTH = 2
) (
   input wire pclk,
   input wire presetn,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** test/boot_mode_ctrl_asserts.sv ***
// Checker of remap, boot ROM map and erase outputs
`timescale 1ns/1ns
`default_nettype none
module boot_mode_ctrl_asserts #(
   parameter ERASE_AW = 10
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [15:0] cpu_addr,
   input wire vector_fetch,
   input wire [15:0] mem_addr,
   input wire boot_rom_sel,
   input wire boot_rom_map_enable,
   input wire special_mode_flag,
   input wire [1:0] op_mode,
   input wire cpu_hold,
   input wire wipe_we,
   input wire [ERASE_AW-1:0] wipe_addr
);
   // All checks on the bus clock, off during reset
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_vl; vector_fetch && special_mode_flag |=> !mem_addr[14]; endproperty
   a_vl: assert property (p_vl) else $error("A14 not low");
   property p_vp; presetn && !(vector_fetch && special_mode_flag) |=> mem_addr == $past(cpu_addr); endproperty
   a_vp: assert property (p_vp) else $error("address altered");
   property p_rs; 1 |=> boot_rom_sel == ($past(boot_rom_map_enable) && $past(cpu_addr) >= 16'hBF00); endproperty
   a_rs: assert property (p_rs) else $error("boot ROM select wrong");
   property p_br; $fell(cpu_hold) && op_mode == 2'b00 |-> boot_rom_map_enable; endproperty
   a_br: assert property (p_br) else $error("map enable not set");
   property p_or; $fell(cpu_hold) && op_mode != 2'b00 |-> !boot_rom_map_enable; endproperty
   a_or: assert property (p_or) else $error("map enable set");
   property p_tw; psel && penable && pwrite && paddr == 12'h000 && pwdata[0]
      && op_mode == 2'b01 && !cpu_hold |=> boot_rom_map_enable; endproperty
   a_tw: assert property (p_tw) else $error("test write lost");
   property p_eh; wipe_we |-> cpu_hold; endproperty
   a_eh: assert property (p_eh) else $error("CPU runs in erase");
   property p_ws; wipe_we && $past(wipe_we) |-> wipe_addr == $past(wipe_addr) + 1'b1; endproperty
   a_ws: assert property (p_ws) else $error("wipe address skipped");
endmodule
bind boot_mode_ctrl boot_mode_ctrl_asserts #(.ERASE_AW(ERASE_AW)) u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .cpu_addr, .vector_fetch, .mem_addr, .boot_rom_sel, .boot_rom_map_enable,
   .special_mode_flag, .op_mode, .cpu_hold, .wipe_we, .wipe_addr);
`default_nettype wire

// *** test/boot_mode_ctrl_bench.sv ***
// Bench for mode selection, remap and security erase
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t %h %h", $time, a, e); end end
module boot_mode_ctrl_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic mode_a_pin = 0, mode_b_pin = 0, vector_fetch = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, zero = 32'h0000_0000;
   logic [15:0] cpu_addr = 16'h0000, mem_addr;
   logic [3:0] wipe_addr;
   logic [1:0] op_mode;
   logic pready, pslverr, er, boot_rom_sel, ee_win_sel, special_mode_flag;
   logic boot_rom_map_enable, cpu_hold, wipe_we, hit;
   int n_errors = 0, checked = 0, wipes = 0;
   boot_mode_ctrl #(.ERASE_WORDS(16), .ERASE_AW(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mode_a_pin(mode_a_pin), .mode_b_pin(mode_b_pin), .cpu_addr(cpu_addr),
      .vector_fetch(vector_fetch), .mem_addr(mem_addr), .boot_rom_sel(boot_rom_sel), .ee_win_sel(ee_win_sel),
      .special_mode_flag(special_mode_flag), .boot_rom_map_enable(boot_rom_map_enable), .op_mode(op_mode),
      .cpu_hold(cpu_hold), .wipe_we(wipe_we), .wipe_addr(wipe_addr));
   ext_mem u_mem (.mem_addr(mem_addr), .boot_rom_sel(boot_rom_sel), .ee_win_sel(ee_win_sel), .hit(hit));
   // Clock and count of wipe cycles
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) if (wipe_we === 1'b1) wipes++;
   task tally_and_finish;
      if (n_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reset with given pins, optionally secure before mode latch
   task boot(input logic [1:0] m, input logic sec);
      @(posedge pclk);
      wipes = 0;
      {mode_b_pin, mode_a_pin} <= m;
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      if (sec) apb(1'b1, 12'h008, 32'h0000_0005);
      while (cpu_hold !== 1'b0) @(posedge pclk);
   endtask
   task fetch(input logic [15:0] a, input logic v);
      @(posedge pclk);
      cpu_addr <= a;
      vector_fetch <= v;
      @(posedge pclk);
      #1;
   endtask
   task t_boot;
      boot(2'b00, 1'b0);
      `CHK(boot_rom_map_enable, 1'b1)
      fetch(16'hFFFE, 1'b1);
      `CHK(mem_addr, 16'hBFFE)
      `CHK(boot_rom_sel, 1'b1)
      apb(1'b1, 12'h008, 32'h0000_0005);
      apb(1'b0, 12'h008, zero);
      `CHK(rd[7:0], 8'h0F)
   endtask
   task t_single;
      boot(2'b10, 1'b0);
      `CHK(boot_rom_map_enable, 1'b0)
      apb(1'b1, 12'h000, 32'h0000_0001);
      fetch(16'hFFFE, 1'b1);
      `CHK(mem_addr, 16'hFFFE)
      `CHK(boot_rom_sel, 1'b0)
      apb(1'b0, 12'h010, zero);
      `CHK({er, rd}, 33'h1_0000_0000)
   endtask
   task t_test;
      boot(2'b01, 1'b0);
      `CHK(boot_rom_map_enable, 1'b0)
      fetch(16'hFFFE, 1'b1);
      `CHK({hit, mem_addr}, 17'h1_BFFE)
      apb(1'b1, 12'h000, 32'h0000_0001);
      fetch(16'hFFFE, 1'b1);
      `CHK(boot_rom_sel, 1'b1)
   endtask
   task t_exp;
      boot(2'b11, 1'b0);
      `CHK(boot_rom_map_enable, 1'b0)
      apb(1'b1, 12'h008, 32'h0000_0005);
      fetch(16'h07FF, 1'b0);
      `CHK(ee_win_sel, 1'b0)
      fetch(16'h0800, 1'b0);
      `CHK(ee_win_sel, 1'b1)
      fetch(16'h0FFF, 1'b0);
      `CHK(ee_win_sel, 1'b1)
      fetch(16'h1000, 1'b0);
      `CHK(ee_win_sel, 1'b0)
   endtask
   task t_sec;
      boot(2'b11, 1'b1);
      `CHK(op_mode, 2'b10)
      `CHK(wipes, 32'h0000_0010)
      apb(1'b1, 12'h008, 32'h0000_000F);
      apb(1'b0, 12'h004, zero);
      `CHK(rd[7], 1'b0)
      `CHK(rd[6], 1'b1)
      `CHK(rd[4], 1'b1)
      boot(2'b01, 1'b1);
      `CHK({op_mode, wipes}, {2'b00, 32'h0000_0010})
      apb(1'b1, 12'h008, 32'h0000_000F);
      apb(1'b0, 12'h004, zero);
      `CHK(rd[7], 1'b1)
   endtask
   initial
   begin
      t_boot();
      t_single();
      t_test();
      t_exp();
      t_sec();
      tally_and_finish();
   end
   initial
   begin
      #50000;
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

// *** test/ext_mem.sv ***
// External memory on the expansion bus
`timescale 1ns/1ns
`default_nettype none
module ext_mem (
   input wire [15:0] mem_addr,
   input wire boot_rom_sel,
   input wire ee_win_sel,
   output logic hit
);
   // Answers only where no on-chip memory claims the address
   assign hit = !boot_rom_sel && !ee_win_sel && (mem_addr !== 16'hxxxx);
endmodule
`default_nettype wire
